// File: design/fuse_read_timer.sv
`timescale 1ns/1ps
`include "otp_trim_defs.svh"

module fuse_read_timer #(
  parameter int OSC_DIV    = `OSC_DIV_CYC,
  parameter int READ_TICKS = `READ_TICKS
) (
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  output logic      osc_en_o,
  output logic      done_o
);
  import otp_trim_pkg::*;

  localparam int DW = $clog2(OSC_DIV);
  localparam int TW = $clog2(READ_TICKS);

  if (OSC_DIV < 2 || READ_TICKS < 2) begin : g_bad
    $error("fuse_read_timer: OSC_DIV and READ_TICKS must be at least 2");
  end

  rd_state_e       state_r, state_nxt;
  logic [DW-1:0]   div_r, div_nxt;
  logic [TW-1:0]   tick_r, tick_nxt;
  logic            done_r, done_nxt;

  always_comb begin
    state_nxt = state_r;
    div_nxt   = div_r;
    tick_nxt  = tick_r;
    done_nxt  = 1'b0;
    case (state_r)
      RD_IDLE: begin
        // RULE_18 busy starts ignored
        // Starts are ignored while running so a cycle is never cut short
        if (start_i) begin
          state_nxt = RD_RUN;
          div_nxt   = '0;
          tick_nxt  = '0;
        end
      end
      RD_RUN: begin
        // RULE_08 oscillator tick counters
        if (div_r == DW'(OSC_DIV - 1)) begin
          div_nxt = '0;
          // RULE_10 read length
          if (tick_r == TW'(READ_TICKS - 1)) begin
            state_nxt = RD_IDLE;
            done_nxt  = 1'b1;
          end else begin
            tick_nxt = tick_r + 1'b1;
          end
        end else begin
          div_nxt = div_r + 1'b1;
        end
      end
      default: state_nxt = RD_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= RD_IDLE;
      div_r   <= '0;
      tick_r  <= '0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      div_r   <= div_nxt;
      tick_r  <= tick_nxt;
      done_r  <= done_nxt;
    end
  end

  // RULE_07 oscillator only during read
  assign osc_en_o = (state_r == RD_RUN);
  assign done_o   = done_r;

  property p_read_len;
    @(posedge mclk_i) disable iff (!resetn_i)
    done_o |-> $past(tick_r) == TW'(READ_TICKS - 1) && $past(div_r) == DW'(OSC_DIV - 1);
  endproperty
  a_read_len: assert property (p_read_len) else $error("read ended at wrong count"); // RULE_10

  property p_osc_off;
    @(posedge mclk_i) disable iff (!resetn_i)
    done_o |-> !osc_en_o ##1 (!osc_en_o || $past(start_i));
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator left on after read"); // RULE_07

endmodule

// File: design/otp_trim_ctrl.sv
// Function
// RULE_01 - Host holds program bit at least 25 ms
// RULE_02 - One burn commits both trim fields together
// RULE_03 - Host loads both trims before programming
// RULE_04 - Program bit selects 8V supply, else 5V
// RULE_05 - Writing read bit starts fuse reload
// RULE_06 - Read bit always reads back zero
// RULE_07 - Oscillator runs only during fuse read
// RULE_08 - Read timing from oscillator-clocked counters (here the counters run on mclk, divided by OSC_DIV)
// RULE_09 - Read starts at power-on reset
// RULE_10 - Fuse load takes about 50 us
// RULE_11 - Read command clears itself
// RULE_12 - All fuse registers load at once
// RULE_13 - Over 165C disables drivers, 25C hysteresis
// RULE_14 - Burned bit refreshed only by reads
// RULE_15 - Switcher trim is bits 5:0
// RULE_16 - Linear trim is bits 3:0
// RULE_17 - Supply raised exactly while bit set
// RULE_18 - Read during read cannot corrupt trims
`timescale 1ns/1ps
`include "otp_trim_defs.svh"

module otp_trim_ctrl #(
  parameter int OSC_DIV    = `OSC_DIV_CYC,
  parameter int READ_TICKS = `READ_TICKS,
  parameter int TRIP_C     = `TSD_TRIP_C,
  parameter int HYST_C     = `TSD_HYST_C
) (
  input  wire logic                    mclk_i,
  input  wire logic                    resetn_i,
  input  wire otp_trim_pkg::reg_req_s  reg_req_i,
  output logic [7:0]                   reg_rdata_o,
  input  wire logic                    en_pin_i,
  input  wire logic                    undervoltage_lockout_ok_i,
  input  wire otp_trim_pkg::fuse_word_s fuse_data_i,
  output logic                         fuse_rd_en_o,
  output logic                         osc_en_o,
  output logic                         fuse_program_supply_hi_o,
  output otp_trim_pkg::fuse_word_s     fuse_prog_word_o,
  output logic [`SW_TRIM_W-1:0]        switcher_trim_o,
  output logic [`LIN_TRIM_W-1:0]       linear_trim_o,
  input  wire logic [7:0]              temp_c_i,
  output logic                         drv_disable_o
);
  import otp_trim_pkg::*;

  function automatic reg_sel_e decode_sel(input logic [7:0] addr);
    if (addr == `SW_TRIM_ADDR) begin
      return SEL_SW;
    end else if (addr == `LIN_TRIM_ADDR) begin
      return SEL_LIN;
    end else if (addr == `FUSE_CTRL_ADDR) begin
      return SEL_CTRL;
    end else begin
      return SEL_NONE;
    end
  endfunction

  logic [`SW_TRIM_W-1:0]  sw_trim_r, sw_trim_nxt;
  logic [`LIN_TRIM_W-1:0] lin_trim_r, lin_trim_nxt;
  logic                   burned_r, burned_nxt;
  logic                   write_r, write_nxt;
  fuse_word_s             prog_r, prog_nxt;
  logic [7:0]             rdata_r, rdata_nxt;
  logic                   pwr_prev_r, pwr_prev_nxt;

  reg_sel_e sel;
  logic     ctrl_wr;
  logic     rd_cmd;
  logic     pwr_ok;
  logic     por_start;
  logic     rd_start;
  logic     rd_done;
  logic     rd_busy;

  assign sel     = decode_sel(reg_req_i.addr);
  assign ctrl_wr = reg_req_i.wr && (sel == SEL_CTRL);

  // RULE_05 read command
  // RULE_11 not stored, so it clears itself
  assign rd_cmd = ctrl_wr && reg_req_i.wdata[`READ_BIT];

  // RULE_09 power-on read
  assign pwr_ok    = en_pin_i && undervoltage_lockout_ok_i;
  assign por_start = pwr_ok && !pwr_prev_r;
  assign rd_start  = rd_cmd || por_start;

  fuse_read_timer #(
    .OSC_DIV    (OSC_DIV),
    .READ_TICKS (READ_TICKS)
  ) u_timer (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .start_i  (rd_start),
    .osc_en_o (rd_busy),
    .done_o   (rd_done)
  );

  thermal_guard #(
    .TRIP_C (TRIP_C),
    .HYST_C (HYST_C)
  ) u_thermal (
    .mclk_i        (mclk_i),
    .resetn_i      (resetn_i),
    .temp_c_i      (temp_c_i),
    .drv_disable_o (drv_disable_o)
  );

  always_comb begin
    sw_trim_nxt  = sw_trim_r;
    lin_trim_nxt = lin_trim_r;
    burned_nxt   = burned_r;
    write_nxt    = write_r;
    prog_nxt     = prog_r;
    pwr_prev_nxt = pwr_ok;

    // RULE_15 switcher trim field
    if (reg_req_i.wr && sel == SEL_SW) begin
      sw_trim_nxt = reg_req_i.wdata[`SW_TRIM_W-1:0];
    end
    // RULE_16 linear trim field
    if (reg_req_i.wr && sel == SEL_LIN) begin
      lin_trim_nxt = reg_req_i.wdata[`LIN_TRIM_W-1:0];
    end
    // RULE_04 supply select
    // RULE_17 no timeout
    if (ctrl_wr) begin
      write_nxt = reg_req_i.wdata[`WRITE_BIT];
    end

    // RULE_02 snapshot both fields
    if (write_nxt && !write_r) begin
      prog_nxt.burned        = 1'b1;
      prog_nxt.switcher_trim = sw_trim_r;
      prog_nxt.linear_trim   = lin_trim_r;
    end

    // RULE_12 simultaneous load
    // RULE_14 burned refreshed only here
    // A host write in the load cycle loses: the fuse copy is what was asked for
    if (rd_done) begin
      sw_trim_nxt  = fuse_data_i.switcher_trim;
      lin_trim_nxt = fuse_data_i.linear_trim;
      burned_nxt   = fuse_data_i.burned;
    end
  end

  // RULE_06 read bit reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (sel)
      SEL_SW: begin
        rdata_nxt[`SW_TRIM_W-1:0] = sw_trim_r;
      end
      SEL_LIN: begin
        rdata_nxt[`LIN_TRIM_W-1:0] = lin_trim_r;
      end
      SEL_CTRL: begin
        rdata_nxt              = `FUSE_CTRL_RST;
        rdata_nxt[`BURNED_BIT] = burned_r;
        rdata_nxt[`WRITE_BIT]  = write_r;
        rdata_nxt[`READ_BIT]   = 1'b0;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sw_trim_r  <= `SW_TRIM_RST;
      lin_trim_r <= `LIN_TRIM_RST;
      burned_r   <= 1'b0;
      write_r    <= 1'b0;
      prog_r     <= '0;
      rdata_r    <= 8'h00;
      pwr_prev_r <= 1'b0;
    end else begin
      sw_trim_r  <= sw_trim_nxt;
      lin_trim_r <= lin_trim_nxt;
      burned_r   <= burned_nxt;
      write_r    <= write_nxt;
      prog_r     <= prog_nxt;
      rdata_r    <= rdata_nxt;
      pwr_prev_r <= pwr_prev_nxt;
    end
  end

  assign reg_rdata_o              = rdata_r;
  // RULE_12 sense covers load
  // The load edge comes one cycle after the oscillator stops, so sensing is held through it
  assign fuse_rd_en_o             = rd_busy || rd_done;
  assign osc_en_o                 = rd_busy;
  assign fuse_program_supply_hi_o = write_r;
  assign fuse_prog_word_o         = prog_r;
  assign switcher_trim_o          = sw_trim_r;
  assign linear_trim_o            = lin_trim_r;

  // Check-only count of mclk cycles with the oscillator on in the current read; a restarted read would overrun it
  localparam logic [31:0] READ_LEN = 32'(OSC_DIV * READ_TICKS);

  logic [31:0] busy_cnt_r, busy_cnt_nxt;

  always_comb begin
    busy_cnt_nxt = 32'h0;
    if (rd_busy) begin
      busy_cnt_nxt = busy_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_cnt_r <= 32'h0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_supply_on_write;
    ctrl_wr |=> fuse_program_supply_hi_o == $past(reg_req_i.wdata[`WRITE_BIT]);
  endproperty
  a_supply_on_write: assert property (p_supply_on_write) else $error("supply not following bit"); // RULE_04

  property p_supply_held;
    fuse_program_supply_hi_o && !ctrl_wr |=> fuse_program_supply_hi_o;
  endproperty
  a_supply_held: assert property (p_supply_held) else $error("supply dropped on its own"); // RULE_17

  property p_both_fields;
    $rose(fuse_program_supply_hi_o) |->
      fuse_prog_word_o.switcher_trim == $past(sw_trim_r) &&
      fuse_prog_word_o.linear_trim == $past(lin_trim_r) && fuse_prog_word_o.burned;
  endproperty
  a_both_fields: assert property (p_both_fields) else $error("burn word not both trims"); // RULE_02

  property p_read_starts;
    rd_cmd && !osc_en_o |=> osc_en_o;
  endproperty
  a_read_starts: assert property (p_read_starts) else $error("read command did not start read"); // RULE_05

  property p_por_read;
    pwr_ok && !pwr_prev_r && !osc_en_o |=> osc_en_o;
  endproperty
  a_por_read: assert property (p_por_read) else $error("no read at power-on"); // RULE_09

  property p_read_zero;
    $past(sel) == SEL_CTRL |-> reg_rdata_o[`READ_BIT] == 1'b0 &&
      reg_rdata_o[`WRITE_BIT] == $past(write_r);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("control read back wrong"); // RULE_06

  property p_load_all;
    rd_done |=> switcher_trim_o == $past(fuse_data_i.switcher_trim) &&
      linear_trim_o == $past(fuse_data_i.linear_trim) && burned_r == $past(fuse_data_i.burned);
  endproperty
  a_load_all: assert property (p_load_all) else $error("fuse load not simultaneous"); // RULE_12

  property p_burned_stable;
    !rd_done |=> $stable(burned_r);
  endproperty
  a_burned_stable: assert property (p_burned_stable) else $error("burned changed outside read"); // RULE_14

  property p_busy_read;
    osc_en_o && rd_cmd |=> (osc_en_o && busy_cnt_r < READ_LEN) || rd_done;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("read during read disturbed cycle"); // RULE_18

  property p_osc_len;
    osc_en_o |-> busy_cnt_r < READ_LEN;
  endproperty
  a_osc_len: assert property (p_osc_len) else $error("read ran past its nominal length"); // RULE_10

  property p_done_len;
    rd_done |-> !osc_en_o && busy_cnt_r == READ_LEN;
  endproperty
  a_done_len: assert property (p_done_len) else $error("read ended early or late"); // RULE_08

  property p_osc_idle;
    !osc_en_o && !rd_start |=> !osc_en_o;
  endproperty
  a_osc_idle: assert property (p_osc_idle) else $error("oscillator on without a read"); // RULE_07

  property p_sw_write;
    reg_req_i.wr && sel == SEL_SW && !rd_done |=> switcher_trim_o == $past(reg_req_i.wdata[`SW_TRIM_W-1:0]);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("switcher trim write lost"); // RULE_15

  property p_lin_write;
    reg_req_i.wr && sel == SEL_LIN && !rd_done |=> linear_trim_o == $past(reg_req_i.wdata[`LIN_TRIM_W-1:0]);
  endproperty
  a_lin_write: assert property (p_lin_write) else $error("linear trim write lost"); // RULE_16

  property p_sw_hold;
    !rd_done && !(reg_req_i.wr && sel == SEL_SW) |=> $stable(switcher_trim_o);
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("switcher trim changed on its own"); // RULE_15

  property p_word_held;
    fuse_program_supply_hi_o && $past(fuse_program_supply_hi_o) |-> $stable(fuse_prog_word_o);
  endproperty
  a_word_held: assert property (p_word_held) else $error("burn word changed during burn"); // RULE_02

endmodule

// File: design/otp_trim_defs.svh
`ifndef OTP_TRIM_DEFS_SVH
`define OTP_TRIM_DEFS_SVH

// Register addresses
`define SW_TRIM_ADDR    8'h01
`define LIN_TRIM_ADDR   8'h02
`define FUSE_CTRL_ADDR  8'hff

// Field layout
`define SW_TRIM_W       6
`define LIN_TRIM_W      4
`define READ_BIT        0
`define WRITE_BIT       2
`define BURNED_BIT      4

// Reset values
`define SW_TRIM_RST     6'h1f
`define LIN_TRIM_RST    4'h7
`define FUSE_CTRL_RST   8'h08

// Timing
`define MCLK_KHZ        100000
`define OSC_KHZ         500
`define READ_TIME_US    50
`define OSC_DIV_CYC     (`MCLK_KHZ / `OSC_KHZ)
`define READ_TICKS      ((`READ_TIME_US * `OSC_KHZ) / 1000)

// Thermal shutdown
`define TSD_TRIP_C      165
`define TSD_HYST_C      25

`endif

// File: design/otp_trim_pkg.sv
`include "otp_trim_defs.svh"

package otp_trim_pkg;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_RUN  = 1'b1
  } rd_state_e;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_SW   = 2'b01,
    SEL_LIN  = 2'b10,
    SEL_CTRL = 2'b11
  } reg_sel_e;

  typedef struct packed {
    logic                     burned;
    logic [`SW_TRIM_W-1:0]    switcher_trim;
    logic [`LIN_TRIM_W-1:0]   linear_trim;
  } fuse_word_s;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

// File: design/thermal_guard.sv
`timescale 1ns/1ps
`include "otp_trim_defs.svh"

module thermal_guard #(
  parameter int TRIP_C = `TSD_TRIP_C,
  parameter int HYST_C = `TSD_HYST_C
) (
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] temp_c_i,
  output logic            drv_disable_o
);
  import otp_trim_pkg::*;

  if (TRIP_C > 255 || HYST_C < 1 || HYST_C > TRIP_C) begin : g_bad
    $error("thermal_guard: trip or hysteresis out of range");
  end

  localparam logic [7:0] TRIP_T = 8'(TRIP_C);
  localparam logic [7:0] REL_T  = 8'(TRIP_C - HYST_C);

  logic hot_r, hot_nxt;

  // RULE_13 trip with hysteresis
  always_comb begin
    hot_nxt = hot_r;
    if (temp_c_i > TRIP_T) begin
      hot_nxt = 1'b1;
    end else if (temp_c_i < REL_T) begin
      hot_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hot_r <= 1'b0;
    end else begin
      hot_r <= hot_nxt;
    end
  end

  assign drv_disable_o = hot_r;

  property p_trip;
    @(posedge mclk_i) disable iff (!resetn_i)
    temp_c_i > TRIP_T |=> drv_disable_o;
  endproperty
  a_trip: assert property (p_trip) else $error("drivers not disabled when hot"); // RULE_13

  property p_hold;
    @(posedge mclk_i) disable iff (!resetn_i)
    drv_disable_o && temp_c_i >= REL_T |=> drv_disable_o;
  endproperty
  a_hold: assert property (p_hold) else $error("released inside hysteresis band"); // RULE_13

endmodule

// File: dv/fuse_array_model.sv
`timescale 1ns/1ps

module fuse_array_model
  import otp_trim_pkg::*;
#(
  parameter int BURN_CYC = 40
) (
  input  wire logic       mclk_i,
  input  wire logic       supply_hi_i,
  input  wire fuse_word_s prog_word_i,
  input  wire logic       rd_en_i,
  output fuse_word_s      data_o
);
  fuse_word_s stored_r = '0;
  int         hold_r   = 0;

  // whole word burns
  // Fuses only take the word if the raised supply lasted long enough
  always @(posedge mclk_i) begin
    if (supply_hi_i) begin
      hold_r <= hold_r + 1;
    end else begin
      if (hold_r >= BURN_CYC) begin
        stored_r <= stored_r | prog_word_i;
      end
      hold_r <= 0;
    end
  end

  // Sense lines are not valid outside a read, so show the inverse
  assign data_o = rd_en_i ? stored_r : ~stored_r;
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps

module testbench;
  import otp_trim_pkg::*;
  localparam int OSC_DIV  = 2;
  localparam int READ_TK  = 2;
  localparam int READ_CYC = OSC_DIV * READ_TK;
  localparam int BURN_CYC = 40;

  logic       mclk, resetn, en_pin, lockout_ok, fuse_rd_en, osc_en, supply_hi, drv_disable;
  reg_req_s   req;
  logic [7:0] rdata, temp_c, rd;
  fuse_word_s fuse_data, prog_word;
  logic [5:0] sw_trim;
  logic [3:0] lin_trim;
  int         err_count, comparisons;

  otp_trim_ctrl #(.OSC_DIV(OSC_DIV), .READ_TICKS(READ_TK)) i_dut (
    .mclk_i(mclk), .resetn_i(resetn), .reg_req_i(req), .reg_rdata_o(rdata),
    .en_pin_i(en_pin), .undervoltage_lockout_ok_i(lockout_ok), .fuse_data_i(fuse_data),
    .fuse_rd_en_o(fuse_rd_en), .osc_en_o(osc_en), .fuse_program_supply_hi_o(supply_hi),
    .fuse_prog_word_o(prog_word), .switcher_trim_o(sw_trim), .linear_trim_o(lin_trim),
    .temp_c_i(temp_c), .drv_disable_o(drv_disable));

  fuse_array_model #(.BURN_CYC(BURN_CYC)) i_fuse (
    .mclk_i(mclk), .supply_hi_i(supply_hi), .prog_word_i(prog_word),
    .rd_en_i(fuse_rd_en), .data_o(fuse_data));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge mclk);
    req.wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    req.addr = a;
    @(posedge mclk);
    #1 d = rdata;
  endtask

  // Entered at the falling edge just after the starting edge
  task automatic measure_read(input bit again, input logic [5:0] sw, input logic [3:0] lin);
    int n;
    n = 0;
    while (osc_en === 1'b1 && n < 100) begin
      check(fuse_rd_en, 1'b1);
      // A second read command mid-read; address and data still stand from the first
      if (again && (n == 1 || n == 2)) begin
        req.wr = (n == 1);
      end
      n++;
      @(negedge mclk);
    end
    check(16'(n), 16'(READ_CYC));
    @(negedge mclk);
    check({sw_trim, lin_trim}, {sw, lin});
  endtask

  task automatic t_reset;
    rd_reg(8'h01, rd);
    check(rd, 8'h1f);
    rd_reg(8'h02, rd);
    check(rd, 8'h07);
    rd_reg(8'hff, rd);
    check(rd, 8'h08);
    rd_reg(8'h10, rd);
    check(rd, 8'h00);
    check({osc_en, supply_hi}, 2'b00);
  endtask

  task automatic t_power_on;
    @(negedge mclk);
    en_pin = 1'b1;
    @(negedge mclk);
    measure_read(1'b0, 6'h00, 4'h0);
    rd_reg(8'hff, rd);
    check(rd, 8'h08);
    // A supply dip below lockout and back must reload over a trial value
    @(negedge mclk);
    lockout_ok = 1'b0;
    wr_reg(8'h01, 8'h33);
    check(sw_trim, 6'h33);
    check(osc_en, 1'b0);
    lockout_ok = 1'b1;
    @(negedge mclk);
    measure_read(1'b0, 6'h00, 4'h0);
  endtask

  task automatic t_trial;
    wr_reg(8'h01, 8'hff);
    check(sw_trim, 6'h3f);
    wr_reg(8'h02, 8'hf5);
    check(lin_trim, 4'h5);
    rd_reg(8'h02, rd);
    check(rd, 8'h05);
    wr_reg(8'h01, 8'hea);
    wr_reg(8'h10, 8'h55);
    rd_reg(8'h01, rd);
    check(rd, 8'h2a);
    rd_reg(8'h10, rd);
    check(rd, 8'h00);
  endtask

  task automatic t_burn;
    wr_reg(8'hff, 8'h04);
    check(supply_hi, 1'b1);
    check(prog_word, {1'b1, 6'h2a, 4'h5});
    // scaled hold of the program bit
    repeat (BURN_CYC + 4) @(negedge mclk);
    check(supply_hi, 1'b1);
    wr_reg(8'hff, 8'h00);
    check(supply_hi, 1'b0);
    rd_reg(8'hff, rd);
    check(rd, 8'h08);
  endtask

  task automatic t_reload;
    wr_reg(8'h01, 8'h11);
    wr_reg(8'hff, 8'h01);
    check(osc_en, 1'b1);
    measure_read(1'b1, 6'h2a, 4'h5);
    rd_reg(8'hff, rd);
    check(rd, 8'h18);
    wr_reg(8'h02, 8'h0c);
    wr_reg(8'hff, 8'h01);
    measure_read(1'b0, 6'h2a, 4'h5);
  endtask

  task automatic t_thermal;
    logic [7:0] temps [5] = '{8'd165, 8'd166, 8'd140, 8'd139, 8'd165};
    logic       exp   [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++) begin
      @(negedge mclk);
      temp_c = temps[i];
      @(negedge mclk);
      check(drv_disable, exp[i]);
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    err_count   = 0;
    comparisons = 0;
    resetn      = 1'b0;
    en_pin      = 1'b0;
    lockout_ok  = 1'b1;
    temp_c      = 8'd25;
    req         = '0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    t_reset();
    t_power_on();
    t_trial();
    t_burn();
    t_reload();
    t_thermal();
    tally_and_finish();
  end
endmodule
